// >>> rtl/tivc_pkg.sv
// constants for the time interval counter block
package tivc_pkg;
    // special-function register addresses
    localparam logic [7:0] ADDR_CTL      = 8'ha1;
    localparam logic [7:0] ADDR_FRAC     = 8'ha2;
    localparam logic [7:0] ADDR_SECOND   = 8'ha3;
    localparam logic [7:0] ADDR_MIN      = 8'ha4;
    localparam logic [7:0] ADDR_HOUR     = 8'ha5;
    localparam logic [7:0] ADDR_CMP      = 8'ha6;
    // control register field positions
    localparam int BIT_CLK_EN = 0;
    localparam int BIT_CNT_EN = 1;
    localparam int BIT_FLAG   = 2;
    localparam int BIT_SINGLE = 3;
    localparam int BIT_SEL_LO = 4;
    localparam int BIT_SEL_HI = 5;
    localparam int BIT_RES6   = 6;
    // reset values
    localparam logic [7:0] RST_CTL  = 8'h00;
    localparam logic [7:0] RST_TIME = 8'h00;
    localparam logic [7:0] RST_CMP  = 8'h00;
    // last value of each time register before it wraps
    localparam logic [7:0] FRAC_LAST = 8'h7f;
    localparam logic [7:0] SECOND_LAST = 8'h3b;
    localparam logic [7:0] MIN_LAST  = 8'h3b;
    localparam logic [7:0] HOUR_LAST = 8'h17;
    // timebase select codes
    localparam logic [1:0] SEL_FRAC = 2'h0;
    localparam logic [1:0] SEL_SECOND = 2'h1;
    localparam logic [1:0] SEL_MIN  = 2'h2;
    localparam logic [1:0] SEL_HOUR = 2'h3;
    // wake vector reported to the core
    localparam logic [15:0] WAKE_VECTOR = 16'h0053;
    // timing: one fraction step is 1/128 s, clock period 25 ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int FRAC_STEP_NS  = 7812500;
    localparam int FRAC_STEP_CYC = FRAC_STEP_NS / CLK_PERIOD_NS;
endpackage

// >>> rtl/tivc_prescale.sv
// divider that makes the 1/128 second step from the system clock
`timescale 1ns/10ps
`default_nettype none
module tivc_prescale #(
    parameter int STEP_CYC = tivc_pkg::FRAC_STEP_CYC
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic run,
    output logic      step
);
    typedef struct packed {
        logic [23:0] cnt;
        logic        step;
    } tivc_pre_t;

    tivc_pre_t s_r;
    tivc_pre_t s_nxt;

    // counter restarts while stopped so the first step is a full period
    always_comb begin
        s_nxt = s_r;
        s_nxt.step = 1'b0;
        if (!run) begin
            s_nxt.cnt = 24'h000000;
        end else if (s_r.cnt == 24'(STEP_CYC - 1)) begin
            s_nxt.cnt  = 24'h000000;
            s_nxt.step = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 24'h000001;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign step = s_r.step;
endmodule
`default_nettype wire

// >>> rtl/tivc_top.sv
// time interval counter: time-of-day chain, interval counter, registers
//
// Behaviour
// [RULE1] software writes bit 6 one, bit 7 reserved
// [RULE2] select field picks step, second, minute, hour
// [RULE3] single mode clears interval enable at timeout
// [RULE4] periodic mode reloads and keeps counting
// [RULE5] counter equal compare sets match flag, interrupt
// [RULE6] only software clears the match flag
// [RULE7] interval enable runs counter; clear zeroes it
// [RULE8] time clock enable gates clock; clear zeroes
// [RULE9] time registers writable only while clock off
// [RULE10] compare register eight bits, resets zero
// [RULE11] fraction counts 0..127 each 1/128 s
// [RULE12] seconds count 0..59, carry to minutes
// [RULE13] minutes count 0..59, carry to hours
// [RULE14] hours count 0..23, wrap without carry
// [RULE15] interval counter steps on selected rollover
// [RULE16] enabled match while powered down wakes core
// [RULE17] chain keeps counting during core power-down
// [RULE18] reload zeroes counter on the matching tick
// [RULE19] reads never see partly updated values
`timescale 1ns/10ps
`default_nettype none
module tivc_top #(
    parameter int STEP_CYC = tivc_pkg::FRAC_STEP_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    input  wire logic        irq_enable,
    input  wire logic        powered_down,
    output logic             irq_req,
    output logic             wake_req,
    output logic      [15:0] wake_vector
);
    typedef struct packed {
        logic [7:0] frac;
        logic [7:0] second;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] cmp;
        logic [7:0] cnt;
        logic       res6;
        logic [1:0] sel;
        logic       single;
        logic       flag;
        logic       cnt_en;
        logic       clk_en;
        logic [7:0] rdata;
        logic       irq;
        logic       wake;
    } tivc_state_t;

    tivc_state_t s_r;
    tivc_state_t s_nxt;
    logic        step;
    logic        ctl_wr;

    // ************************************************************
    // fraction step source
    // ************************************************************

    // the whole chain sits on the free-running clock, so core
    // power-down does not stop it
    tivc_prescale #(
        .STEP_CYC (STEP_CYC)
    ) u_pre (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .run      (s_r.clk_en),
        .step     (step)
    ); // RULE17 RULE8

    assign ctl_wr = sfr_wr && (sfr_addr == tivc_pkg::ADDR_CTL);

    // control register as software reads it; bit 7 reads zero
    function automatic logic [7:0] ctl_word(input tivc_state_t s);
        ctl_word = {1'b0, s.res6, s.sel, s.single, s.flag, s.cnt_en,
                    s.clk_en};
    endfunction

    // ************************************************************
    // next state
    // ************************************************************

    // writes are applied first, then the step, so a hardware set
    // of the flag in the same cycle as a clear wins
    always_comb begin
        logic unit;
        logic frac_wrap;
        logic sec_wrap;
        logic min_wrap;
        logic [7:0] inc;
        unit      = 1'b0;
        frac_wrap = 1'b0;
        sec_wrap  = 1'b0;
        min_wrap  = 1'b0;
        inc       = 8'h00;
        s_nxt     = s_r;
        // register writes
        if (ctl_wr) begin
            s_nxt.res6 = sfr_wdata[tivc_pkg::BIT_RES6]; // RULE1
            s_nxt.sel  = sfr_wdata[tivc_pkg::BIT_SEL_HI:tivc_pkg::BIT_SEL_LO];
            s_nxt.single = sfr_wdata[tivc_pkg::BIT_SINGLE];
            s_nxt.flag = s_r.flag & sfr_wdata[tivc_pkg::BIT_FLAG]; // RULE6
            s_nxt.cnt_en = sfr_wdata[tivc_pkg::BIT_CNT_EN];
            s_nxt.clk_en = sfr_wdata[tivc_pkg::BIT_CLK_EN];
            if (!sfr_wdata[tivc_pkg::BIT_CLK_EN] && s_r.clk_en) begin
                s_nxt.frac   = tivc_pkg::RST_TIME; // RULE8
                s_nxt.second = tivc_pkg::RST_TIME;
                s_nxt.min  = tivc_pkg::RST_TIME;
                s_nxt.hour = tivc_pkg::RST_TIME;
                s_nxt.cnt  = 8'h00;
            end
        end else if (sfr_wr && sfr_addr == tivc_pkg::ADDR_CMP) begin
            s_nxt.cmp = sfr_wdata; // RULE10
        end else if (sfr_wr && !s_r.clk_en) begin
            // a running chain ignores preloads to avoid torn time
            if (sfr_addr == tivc_pkg::ADDR_FRAC) begin
                s_nxt.frac = sfr_wdata; // RULE9
            end else if (sfr_addr == tivc_pkg::ADDR_SECOND) begin
                s_nxt.second = sfr_wdata;
            end else if (sfr_addr == tivc_pkg::ADDR_MIN) begin
                s_nxt.min = sfr_wdata;
            end else if (sfr_addr == tivc_pkg::ADDR_HOUR) begin
                s_nxt.hour = sfr_wdata;
            end
        end
        // time-of-day chain
        if (step && s_nxt.clk_en) begin
            frac_wrap = (s_nxt.frac == tivc_pkg::FRAC_LAST);
            s_nxt.frac = frac_wrap ? 8'h00 : s_nxt.frac + 8'h01; // RULE11
            if (frac_wrap) begin
                sec_wrap = (s_nxt.second == tivc_pkg::SECOND_LAST);
                s_nxt.second = sec_wrap ? 8'h00
                               : s_nxt.second + 8'h01; // RULE12
            end
            if (sec_wrap) begin
                min_wrap = (s_nxt.min == tivc_pkg::MIN_LAST);
                s_nxt.min = min_wrap ? 8'h00 : s_nxt.min + 8'h01; // RULE13
            end
            if (min_wrap) begin
                s_nxt.hour = (s_nxt.hour == tivc_pkg::HOUR_LAST) ?
                             8'h00 : s_nxt.hour + 8'h01; // RULE14
            end
            case (s_nxt.sel)
                tivc_pkg::SEL_FRAC:   unit = 1'b1; // RULE2 RULE15
                tivc_pkg::SEL_SECOND: unit = frac_wrap;
                tivc_pkg::SEL_MIN:    unit = sec_wrap;
                default:              unit = min_wrap;
            endcase
        end
        // interval counter
        if (unit && s_nxt.cnt_en) begin
            inc = s_nxt.cnt + 8'h01;
            if (inc == s_nxt.cmp) begin
                s_nxt.flag = 1'b1; // RULE5
                s_nxt.cnt  = 8'h00; // RULE18 RULE4
                if (s_nxt.single) begin
                    s_nxt.cnt_en = 1'b0; // RULE3
                end
            end else begin
                s_nxt.cnt = inc;
            end
        end
        if (!s_nxt.cnt_en) begin
            s_nxt.cnt = 8'h00; // RULE7
        end
        // read data; one clock domain, so every read is whole
        s_nxt.rdata = 8'h00; // RULE19
        if (sfr_rd) begin
            if (sfr_addr == tivc_pkg::ADDR_CTL) begin
                s_nxt.rdata = ctl_word(s_r);
            end else if (sfr_addr == tivc_pkg::ADDR_FRAC) begin
                s_nxt.rdata = s_r.frac;
            end else if (sfr_addr == tivc_pkg::ADDR_SECOND) begin
                s_nxt.rdata = s_r.second;
            end else if (sfr_addr == tivc_pkg::ADDR_MIN) begin
                s_nxt.rdata = s_r.min;
            end else if (sfr_addr == tivc_pkg::ADDR_HOUR) begin
                s_nxt.rdata = s_r.hour;
            end else if (sfr_addr == tivc_pkg::ADDR_CMP) begin
                s_nxt.rdata = s_r.cmp;
            end
        end
        s_nxt.irq  = s_nxt.flag && irq_enable; // RULE5
        s_nxt.wake = s_nxt.flag && irq_enable && powered_down; // RULE16
    end

    // ************************************************************
    // state register
    // ************************************************************

    // state register; all fields reset to zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sfr_rdata   = s_r.rdata;
    assign irq_req     = s_r.irq;
    assign wake_req    = s_r.wake;
    assign wake_vector = tivc_pkg::WAKE_VECTOR;

    // ************************************************************
    // checks
    // ************************************************************

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    logic run_step;
    logic unit_hit;
    assign run_step = step && s_r.clk_en && !sfr_wr;
    assign unit_hit = run_step && s_r.cnt_en && s_r.sel == tivc_pkg::SEL_FRAC
                      && (s_r.cnt + 8'h01) == s_r.cmp;

    a_frac_wrap: assert property (run_step // RULE11
        && s_r.frac == tivc_pkg::FRAC_LAST
        |=> s_r.frac == 8'h00 && s_r.second != $past(s_r.second))
        else $error("fraction did not wrap into seconds");
    a_second_wrap: assert property (run_step // RULE12
        && s_r.frac == tivc_pkg::FRAC_LAST
        && s_r.second == tivc_pkg::SECOND_LAST |=> s_r.second == 8'h00)
        else $error("seconds did not wrap at 59");
    a_min_wrap: assert property (run_step // RULE13
        && s_r.frac == tivc_pkg::FRAC_LAST
        && s_r.second == tivc_pkg::SECOND_LAST
        && s_r.min == tivc_pkg::MIN_LAST |=> s_r.min == 8'h00)
        else $error("minutes did not wrap at 59");
    // the request follows the enable of the cycle that set the flag
    a_match_set: assert property (unit_hit // RULE5
        |=> s_r.flag && s_r.irq == $past(irq_enable))
        else $error("match did not set flag and request");
    a_oneshot_stop: assert property (unit_hit && s_r.single // RULE3
        |=> !s_r.cnt_en && s_r.cnt == 8'h00)
        else $error("single interval did not stop");
    a_reload_run: assert property (unit_hit && !s_r.single // RULE18
        |=> s_r.cnt_en && s_r.cnt == 8'h00)
        else $error("periodic interval did not reload");
    // a control write may enable the counter and step it at once
    a_idle_zero: assert property (!s_r.cnt_en && !ctl_wr // RULE7
        |=> s_r.cnt == 8'h00)
        else $error("disabled interval counter not zero");
    a_clock_clear: assert property (ctl_wr && s_r.clk_en // RULE8
        && !sfr_wdata[tivc_pkg::BIT_CLK_EN]
        |=> s_r.frac == 8'h00 && s_r.hour == 8'h00 && s_r.cnt == 8'h00)
        else $error("clock disable did not clear time");
    a_preload_ok: assert property (sfr_wr && !s_r.clk_en // RULE9
        && sfr_addr == tivc_pkg::ADDR_MIN |=> s_r.min == $past(sfr_wdata))
        else $error("preload while stopped was lost");
    a_flag_hold: assert property (s_r.flag && !ctl_wr |=> s_r.flag) // RULE6
        else $error("match flag cleared without software");
    // a software clear in the same cycle legitimately drops the wake
    a_wake_req: assert property (s_r.flag && irq_enable // RULE16
        && powered_down && !ctl_wr |=> wake_req)
        else $error("no wake on enabled match");
endmodule
`default_nettype wire

// >>> verification/tivc_top_tb.sv
// self-checking bench for the time interval counter
`timescale 1ns/10ps
`default_nettype none
module tivc_top_tb;
    localparam int S = 4; // short step keeps every interval brief
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_rdata;
    logic        irq_enable = 1'b0;
    logic        powered_down = 1'b0;
    logic        irq_req;
    logic        wake_req;
    logic [15:0] wake_vector;
    logic [7:0]  d;
    int          failures = 0;
    int          compares = 0;
    int          cyc = 0;
    int          t0;

    tivc_top #(.STEP_CYC(S)) dut (
        .clk_sys     (clk_sys),
        .nrst        (nrst),
        .sfr_addr    (sfr_addr),
        .sfr_wdata   (sfr_wdata),
        .sfr_wr      (sfr_wr),
        .sfr_rd      (sfr_rd),
        .sfr_rdata   (sfr_rdata),
        .irq_enable  (irq_enable),
        .powered_down(powered_down),
        .irq_req     (irq_req),
        .wake_req    (wake_req),
        .wake_vector (wake_vector)
    );

    // free cycle count gives exact spacing between events
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    // ******************************************************
    // bus and checking helpers
    // ******************************************************
    task automatic summarize();
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        #2 sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(posedge clk_sys);
        #2 sfr_wr = 1'b0;
    endtask
    // read data is registered, so it is taken one edge after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        #2 sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk_sys);
        #2 sfr_rd = 1'b0;
        v = sfr_rdata;
    endtask
    // bounded wait on the interrupt level; a hang closes the run
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 2000 && irq_req !== lvl; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (irq_req !== lvl) begin
            failures++;
            summarize();
        end
    endtask

    // ******************************************************
    // scenarios
    // ******************************************************
    task automatic t_reset();
        for (int a = 8'ha0; a <= 8'ha7; a++) begin
            rd(8'(a), d);
            chk("reset value", {8'h00, d}, 16'h0000);
        end
        wr(tivc_pkg::ADDR_CMP, 8'hff);
        rd(tivc_pkg::ADDR_CMP, d);
        chk("compare max", {8'h00, d}, 16'h00ff);
    endtask
    // full chain rollover from the last value of every register
    task automatic t_chain();
        wr(tivc_pkg::ADDR_FRAC, 8'h7f);
        wr(tivc_pkg::ADDR_SECOND, 8'h3b);
        wr(tivc_pkg::ADDR_MIN, 8'h3b);
        wr(tivc_pkg::ADDR_HOUR, 8'h17);
        rd(tivc_pkg::ADDR_HOUR, d);
        chk("hour preload", {8'h00, d}, 16'h0017);
        wr(tivc_pkg::ADDR_CTL, 8'h41);
        for (int i = 0; i < 40; i++) begin
            rd(tivc_pkg::ADDR_HOUR, d);
            if (d === 8'h00) break;
        end
        chk("hour wrap", {8'h00, d}, 16'h0000);
        wr(tivc_pkg::ADDR_SECOND, 8'h05);
        rd(tivc_pkg::ADDR_MIN, d);
        chk("minute wrap", {8'h00, d}, 16'h0000);
        rd(tivc_pkg::ADDR_SECOND, d);
        chk("second wrap", {8'h00, d}, 16'h0000);
        rd(tivc_pkg::ADDR_FRAC, d);
        chk("fraction runs", {15'h0, d != 8'h00}, 16'h0001);
        wr(tivc_pkg::ADDR_CTL, 8'h40);
        rd(tivc_pkg::ADDR_FRAC, d);
        chk("fraction cleared", {8'h00, d}, 16'h0000);
    endtask
    task automatic t_periodic();
        wr(tivc_pkg::ADDR_CMP, 8'h03);
        irq_enable = 1'b1;
        wr(tivc_pkg::ADDR_CTL, 8'h43);
        wait_irq(1'b1);
        t0 = cyc;
        wr(tivc_pkg::ADDR_CTL, 8'h43);
        wait_irq(1'b0);
        wait_irq(1'b1);
        chk("reload spacing", 16'(cyc - t0), 16'(3 * S));
        rd(tivc_pkg::ADDR_CTL, d);
        chk("control periodic", {8'h00, d}, 16'h0047);
        irq_enable = 1'b0;
        repeat (2) @(posedge clk_sys);
        #2 chk("irq masked", {15'h0, irq_req}, 16'h0000);
        irq_enable = 1'b1;
        powered_down = 1'b1;
        repeat (2) @(posedge clk_sys);
        #2 chk("wake", {15'h0, wake_req}, 16'h0001);
        chk("wake vector", wake_vector, 16'h0053);
        powered_down = 1'b0;
        wr(tivc_pkg::ADDR_CTL, 8'h40);
    endtask
    // one-shot: enable falls, flag holds until software clears it
    task automatic t_single();
        wr(tivc_pkg::ADDR_CMP, 8'h02);
        wr(tivc_pkg::ADDR_CTL, 8'h4b);
        wait_irq(1'b1);
        rd(tivc_pkg::ADDR_CTL, d);
        chk("one shot", {8'h00, d}, 16'h004d);
        repeat (3 * S) @(posedge clk_sys);
        rd(tivc_pkg::ADDR_CTL, d);
        chk("flag held", {8'h00, d}, 16'h004d);
        wr(tivc_pkg::ADDR_CTL, 8'h49);
        repeat (4 * S) @(posedge clk_sys);
        #1 chk("no rerun", {15'h0, irq_req}, 16'h0000);
        rd(tivc_pkg::ADDR_CTL, d);
        chk("flag cleared", {8'h00, d}, 16'h0049);
    endtask
    // each select code fires on the first step only when every lower
    // register is preloaded to wrap there; one level short stays quiet
    task automatic t_select();
        for (int k = 0; k < 4; k++) begin
            for (int n = k - 1; n <= k; n++) begin
                if (n < 0) continue;
                wr(tivc_pkg::ADDR_CTL, 8'h40);
                if (n > 0) wr(tivc_pkg::ADDR_FRAC, 8'h7f);
                if (n > 1) wr(tivc_pkg::ADDR_SECOND, 8'h3b);
                if (n > 2) wr(tivc_pkg::ADDR_MIN, 8'h3b);
                wr(tivc_pkg::ADDR_CMP, 8'h01);
                wr(tivc_pkg::ADDR_CTL, {2'b01, 2'(k), 4'h3});
                t0 = cyc;
                if (n == k) begin
                    // first step a full period after enabling, flag next
                    wait_irq(1'b1);
                    chk("select", 16'(cyc - t0), 16'(S + 1));
                end else begin
                    repeat (S + 2) @(posedge clk_sys);
                    #2 chk("idle", {15'h0, irq_req}, 16'h0000);
                end
            end
        end
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        #2 nrst = 1'b1;
        t_reset();
        t_chain();
        t_periodic();
        t_single();
        t_select();
        summarize();
    end
endmodule
`default_nettype wire
